// File: hw/uhc_pkg.sv
// Constants shared by the USB endpoint handshake controller
package uhc_pkg;
  // Register indices on the CPU register port
  localparam logic [3:0] OFF_TOKEN_PID  = 4'h0;
  localparam logic [3:0] OFF_DMA_HIGH   = 4'h1;
  localparam logic [3:0] OFF_DMA_LOW_ID = 4'h2;
  localparam logic [3:0] OFF_INT_STATUS = 4'h3;
  localparam logic [3:0] OFF_INT_MASK   = 4'h4;
  localparam logic [3:0] OFF_CONTROL    = 4'h5;
  localparam logic [3:0] OFF_DEV_ADDR   = 4'h6;
  localparam logic [3:0] OFF_EP0_TX     = 4'h7;
  localparam logic [3:0] OFF_EP0_RX     = 4'h8;

  localparam int EP_COUNT = 3;

  // Endpoint register fields
  localparam int FLD_TOP    = 7;
  localparam int FLD_TOGGLE = 6;
  localparam int FLD_STAT_H = 5;
  localparam int FLD_STAT_L = 4;
  localparam int FLD_LOW_H  = 3;

  // Interrupt status bits
  localparam int IS_DOVR  = 6;
  localparam int IS_CTR   = 5;
  localparam int IS_ERR   = 4;
  localparam int IS_IOVR  = 3;
  localparam int IS_SUSPEND_END_FLAG = 2;
  localparam int IS_RESET = 1;
  localparam int IS_SOF   = 0;

  // Control register bits
  localparam int CT_RESUME = 3;
  localparam int CT_PDWN   = 2;
  localparam int CT_SUSP   = 1;
  localparam int CT_FRES   = 0;

  // Reset values and masks
  localparam logic [7:0] RST_EP_TX      = 8'h00;
  localparam logic [7:0] RST_EP_RX      = 8'h00;
  localparam logic [7:0] RST_EP0_RX     = 8'h80;
  localparam logic [7:0] EP0_RX_WMASK   = 8'h70;
  localparam logic [7:0] RST_CONTROL    = 8'h06;
  localparam logic [7:0] CONTROL_MASK   = 8'h0F;
  localparam logic [7:0] INT_MASK_BITS  = 8'h7F;

  // Endpoint status codes
  localparam logic [1:0] STAT_DISABLED = 2'h0;
  localparam logic [1:0] STAT_STALL    = 2'h1;
  localparam logic [1:0] STAT_NAK      = 2'h2;
  localparam logic [1:0] STAT_VALID    = 2'h3;

  // Token PID bits 3:2
  localparam logic [1:0] TOK_OUT   = 2'h0;
  localparam logic [1:0] TOK_IN    = 2'h2;
  localparam logic [1:0] TOK_SETUP = 2'h3;

  // Answer codes towards the packet engine
  localparam logic [2:0] RESP_NONE  = 3'h0;
  localparam logic [2:0] RESP_ACK   = 3'h1;
  localparam logic [2:0] RESP_NAK   = 3'h2;
  localparam logic [2:0] RESP_STALL = 3'h3;
  localparam logic [2:0] RESP_DATA  = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DATA = 3'b010,
    ST_ACK  = 3'b100
  } uhc_state_type;
endpackage

// File: hw/uhc_endpoint_ctrl.sv
// Endpoint status, toggle and handshake control for a three-endpoint USB function
//
// Overview of operation
// - Transmit status: disabled, stall, NAK, valid
// - Correct IN or SETUP sets transmit NAK
// - Send exactly the programmed byte count, 0-8
// - Receive status: disabled, stall, NAK, valid
// - Correct OUT or SETUP sets receive NAK
// - SETUP stage clears expected receive toggle
// - Receive toggle flips on good matching packet
// - Endpoints 1,2 match programmed endpoint number
// - Control bit marks control endpoint; endpoint 0 always
// - Endpoint 0 receive reads 1xxx0000, resets 0x80
// - USB bus reset restores endpoint registers
// - Packet buffers: 48 bytes above aligned base
// - USB reset clears address, disables all endpoints
// - Pending correct transfer NAKs every valid endpoint; here a nonzero OUT under status-out is answered STALL instead
// - Correct SETUP NAKs both directions
// - Token and endpoint frozen while flag set
// - Activity in suspend raises end-of-suspend flag
// - SETUP sets transmit toggle; ACK flips it
// - Correct means error-free, handshake not NAK/STALL
// - Status-out stalls nonzero OUT data
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ns
module uhc_endpoint_ctrl (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        tok_valid_i,
  input  wire logic [1:0]  tok_pid_i,
  input  wire logic [6:0]  tok_addr_i,
  input  wire logic [3:0]  tok_ep_i,
  input  wire logic        rx_done_i,
  input  wire logic        rx_ok_i,
  input  wire logic        rx_data_pid_i,
  input  wire logic [3:0]  rx_len_i,
  input  wire logic        hs_ack_i,
  input  wire logic        bus_reset_i,
  input  wire logic        bus_activity_i,
  input  wire logic        sof_i,
  input  wire logic        dma_late_i,
  input  wire logic [2:0]  dma_idx_i,
  output logic             resp_valid_o,
  output logic      [2:0]  resp_code_o,
  output logic             resp_toggle_o,
  output logic      [3:0]  resp_len_o,
  output logic      [15:0] dma_addr_o,
  output logic             suspend_o,
  output logic             resume_o,
  output logic             power_down_o
);

  logic [7:0]                 ep_tx [uhc_pkg::EP_COUNT];
  logic [7:0]                 ep_rx [uhc_pkg::EP_COUNT];
  logic [7:0]                 int_status;
  logic [7:0]                 int_mask;
  logic [7:0]                 control;
  logic [6:0]                 dev_addr;
  logic [7:0]                 dma_high;
  logic [1:0]                 dma_low;
  logic [1:0]                 tok_pid;
  logic [1:0]                 last_ep;
  logic [3:0]                 rx_count;
  logic [1:0]                 cur_ep;
  logic [1:0]                 cur_pid;
  uhc_pkg::uhc_state_type     state;
  uhc_pkg::uhc_state_type     next_state;

  // Answer for a status field; ok_code when the endpoint may take data
  function automatic logic [2:0] stat_resp(input logic [1:0] stat, input logic ctr,
                                           input logic [2:0] ok_code);
    case (stat)
      uhc_pkg::STAT_STALL:    stat_resp = uhc_pkg::RESP_STALL;
      uhc_pkg::STAT_NAK:      stat_resp = uhc_pkg::RESP_NAK;
      uhc_pkg::STAT_VALID:    stat_resp = ctr ? uhc_pkg::RESP_NAK : ok_code;
      default:                stat_resp = uhc_pkg::RESP_NONE;
    endcase
  endfunction

  // Endpoint 0 is always a control endpoint
  function automatic logic ep_is_ctrl(input logic [1:0] idx, input logic [7:0] rx_reg);
    ep_is_ctrl = (idx == 2'h0) || rx_reg[uhc_pkg::FLD_TOP];
  endfunction

  // Register decode
  wire bus_rst = bus_reset_i || control[uhc_pkg::CT_FRES];
  wire ctr     = int_status[uhc_pkg::IS_CTR];
  wire wr_stat = reg_we_i && reg_addr_i == uhc_pkg::OFF_INT_STATUS;
  wire wr_ctl  = reg_we_i && reg_addr_i == uhc_pkg::OFF_CONTROL;
  logic [uhc_pkg::EP_COUNT-1:0] wr_tx;
  logic [uhc_pkg::EP_COUNT-1:0] wr_rx;
  logic [uhc_pkg::EP_COUNT-1:0] ep_hit;

  genvar g;
  generate
    for (g = 0; g < uhc_pkg::EP_COUNT; g++)
    begin : g_ep_dec
      assign wr_tx[g]  = reg_we_i && reg_addr_i == uhc_pkg::OFF_EP0_TX + 4'(2 * g);
      assign wr_rx[g]  = reg_we_i && reg_addr_i == uhc_pkg::OFF_EP0_RX + 4'(2 * g);
      if (g == 0)
      begin : g_ep0
        assign ep_hit[g] = tok_ep_i == 4'h0;
      end
      else
      begin : g_epn
        assign ep_hit[g] = tok_ep_i == ep_rx[g][uhc_pkg::FLD_LOW_H:0];
      end
    end
  endgenerate

  // Token side
  wire       tok_go    = tok_valid_i && tok_addr_i == dev_addr && |ep_hit;
  wire [1:0] tok_idx   = ep_hit[0] ? 2'h0 : (ep_hit[1] ? 2'h1 : 2'h2);
  wire [7:0] tok_tx    = ep_tx[tok_idx];
  wire [1:0] tok_stat  = tok_tx[uhc_pkg::FLD_STAT_H:uhc_pkg::FLD_STAT_L];
  wire       tok_in_go = tok_go && tok_pid_i == uhc_pkg::TOK_IN;
  wire [2:0] in_resp   = stat_resp(tok_stat, ctr, uhc_pkg::RESP_DATA);
  wire       setup_tok = tok_go && tok_pid_i == uhc_pkg::TOK_SETUP
                         && ep_is_ctrl(tok_idx, ep_rx[tok_idx]);

  // Data side, against the endpoint latched at the token
  wire [7:0] cur_tx    = ep_tx[cur_ep];
  wire [7:0] cur_rx    = ep_rx[cur_ep];
  wire [1:0] cur_rstat = cur_rx[uhc_pkg::FLD_STAT_H:uhc_pkg::FLD_STAT_L];
  wire       rx_evt    = state == uhc_pkg::ST_DATA && rx_done_i;
  wire       stout_bad = cur_pid == uhc_pkg::TOK_OUT && cur_tx[uhc_pkg::FLD_TOP]
                         && rx_len_i != 4'h0;
  wire       setup_bad = cur_pid == uhc_pkg::TOK_SETUP && !ep_is_ctrl(cur_ep, cur_rx);
  wire [2:0] rx_base   = stat_resp(cur_rstat, ctr, uhc_pkg::RESP_ACK);
  wire [2:0] rx_resp   = (!rx_ok_i || setup_bad) ? uhc_pkg::RESP_NONE :
                         (stout_bad && cur_rstat != uhc_pkg::STAT_DISABLED) ?
                         uhc_pkg::RESP_STALL : rx_base;
  wire       tog_ok    = rx_data_pid_i == cur_rx[uhc_pkg::FLD_TOGGLE];
  // A duplicate packet with the wrong toggle is ACKed but never counted
  wire       ev_rx_ok  = rx_evt && rx_resp == uhc_pkg::RESP_ACK && tog_ok;
  wire       ev_in_ok  = state == uhc_pkg::ST_ACK && hs_ack_i;
  wire       ctr_set   = ev_in_ok || ev_rx_ok;

  // Event flags; software clears by writing zero, a same-cycle event wins
  wire       err_set   = rx_evt && !rx_ok_i;
  wire       suspend_end_flag_set = control[uhc_pkg::CT_SUSP] && bus_activity_i;
  wire       iovr_set  = (err_set && int_status[uhc_pkg::IS_ERR])
                         || (suspend_end_flag_set && int_status[uhc_pkg::IS_SUSPEND_END_FLAG])
                         || (sof_i && int_status[uhc_pkg::IS_SOF]);
  wire [7:0] stat_sets = {1'b0, dma_late_i, ctr_set, err_set, iovr_set, suspend_end_flag_set,
                          bus_rst, sof_i};
  wire [7:0] stat_keep = wr_stat ? reg_wdata_i : 8'hFF;
  wire [7:0] next_int_status = ((int_status & stat_keep) | stat_sets)
                               & uhc_pkg::INT_MASK_BITS;

  // Hardware clears suspend on bus activity, over any software write
  wire [7:0] ctl_wr       = wr_ctl ? (reg_wdata_i & uhc_pkg::CONTROL_MASK) : control;
  wire [7:0] next_control = suspend_end_flag_set ? (ctl_wr & ~(8'h01 << uhc_pkg::CT_SUSP)) : ctl_wr;

  // Next state
  always_comb
  begin
    next_state = state;
    case (state)
      uhc_pkg::ST_IDLE: next_state = uhc_pkg::ST_IDLE;
      uhc_pkg::ST_DATA: next_state = rx_done_i ? uhc_pkg::ST_IDLE : uhc_pkg::ST_DATA;
      uhc_pkg::ST_ACK:  next_state = hs_ack_i ? uhc_pkg::ST_IDLE : uhc_pkg::ST_ACK;
      default:          next_state = uhc_pkg::ST_IDLE;
    endcase
    // A new token always restarts the transaction
    if (tok_valid_i)
    begin
      if (!tok_go)
        next_state = uhc_pkg::ST_IDLE;
      else if (tok_pid_i == uhc_pkg::TOK_IN)
        next_state = (in_resp == uhc_pkg::RESP_DATA) ? uhc_pkg::ST_ACK : uhc_pkg::ST_IDLE;
      else
        next_state = uhc_pkg::ST_DATA;
    end
    if (bus_rst)
      next_state = uhc_pkg::ST_IDLE;
  end

  // Register read selection; a process, so register contents wake it as well as the address
  logic [7:0] rd_mux;
  always_comb
    case (reg_addr_i)
      uhc_pkg::OFF_TOKEN_PID:  rd_mux = {tok_pid, 6'h00};
      uhc_pkg::OFF_DMA_HIGH:   rd_mux = dma_high;
      uhc_pkg::OFF_DMA_LOW_ID: rd_mux = {dma_low, last_ep, rx_count};
      uhc_pkg::OFF_INT_STATUS: rd_mux = int_status;
      uhc_pkg::OFF_INT_MASK:   rd_mux = int_mask;
      uhc_pkg::OFF_CONTROL:    rd_mux = control;
      uhc_pkg::OFF_DEV_ADDR:   rd_mux = {1'b0, dev_addr};
      uhc_pkg::OFF_EP0_TX:     rd_mux = ep_tx[0];
      uhc_pkg::OFF_EP0_RX:     rd_mux = ep_rx[0];
      4'h9:                    rd_mux = ep_tx[1];
      4'hA:                    rd_mux = ep_rx[1];
      4'hB:                    rd_mux = ep_tx[2];
      4'hC:                    rd_mux = ep_rx[2];
      default:                 rd_mux = 8'h00;
    endcase

  // Endpoint registers
  always_ff @(posedge mclk_i)
  begin
    for (int i = 0; i < uhc_pkg::EP_COUNT; i++)
    begin
      if (rst_i || bus_rst)
      begin
        ep_tx[i] <= uhc_pkg::RST_EP_TX;
        ep_rx[i] <= (i == 0) ? uhc_pkg::RST_EP0_RX : uhc_pkg::RST_EP_RX;
      end
      else
      begin
        if (wr_tx[i])
          ep_tx[i] <= reg_wdata_i;
        if (wr_rx[i])
          ep_rx[i] <= (i == 0) ? ((reg_wdata_i & uhc_pkg::EP0_RX_WMASK) | uhc_pkg::RST_EP0_RX)
                               : reg_wdata_i;
        // Later assignments below override a same-cycle software write
        if (setup_tok && tok_idx == 2'(i))
        begin
          ep_rx[i][uhc_pkg::FLD_TOGGLE] <= 1'b0;
          ep_tx[i][uhc_pkg::FLD_TOGGLE] <= 1'b1;
        end
        if (ev_in_ok && cur_ep == 2'(i))
        begin
          ep_tx[i][uhc_pkg::FLD_TOGGLE] <= ~ep_tx[i][uhc_pkg::FLD_TOGGLE];
          ep_tx[i][uhc_pkg::FLD_STAT_H:uhc_pkg::FLD_STAT_L] <= uhc_pkg::STAT_NAK;
        end
        if (ev_rx_ok && cur_ep == 2'(i))
        begin
          ep_rx[i][uhc_pkg::FLD_TOGGLE] <= ~ep_rx[i][uhc_pkg::FLD_TOGGLE];
          ep_rx[i][uhc_pkg::FLD_STAT_H:uhc_pkg::FLD_STAT_L] <= uhc_pkg::STAT_NAK;
          if (cur_pid == uhc_pkg::TOK_SETUP)
            ep_tx[i][uhc_pkg::FLD_STAT_H:uhc_pkg::FLD_STAT_L] <= uhc_pkg::STAT_NAK;
        end
      end
    end
  end

  // Global registers
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      int_status <= 8'h00;
      int_mask   <= 8'h00;
      control    <= uhc_pkg::RST_CONTROL;
      dev_addr   <= 7'h00;
      dma_high   <= 8'h00;
      dma_low    <= 2'h0;
      tok_pid    <= 2'h0;
      last_ep    <= 2'h0;
      rx_count   <= 4'h0;
    end
    else
    begin
      int_status <= next_int_status;
      control    <= next_control;
      if (reg_we_i && reg_addr_i == uhc_pkg::OFF_INT_MASK)
        int_mask <= reg_wdata_i & uhc_pkg::INT_MASK_BITS;
      if (reg_we_i && reg_addr_i == uhc_pkg::OFF_DMA_HIGH)
        dma_high <= reg_wdata_i;
      if (reg_we_i && reg_addr_i == uhc_pkg::OFF_DMA_LOW_ID)
        dma_low <= reg_wdata_i[7:6];
      if (bus_rst)
        dev_addr <= 7'h00;
      else if (reg_we_i && reg_addr_i == uhc_pkg::OFF_DEV_ADDR)
        dev_addr <= reg_wdata_i[6:0];
      // Capture only on the event that raises the flag, then hold
      if (ctr_set && !ctr)
      begin
        tok_pid  <= cur_pid;
        last_ep  <= cur_ep;
        rx_count <= ev_rx_ok ? rx_len_i : 4'h0;
      end
    end
  end

  // Transaction state and answers to the packet engine
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      state         <= uhc_pkg::ST_IDLE;
      cur_ep        <= 2'h0;
      cur_pid       <= 2'h0;
      resp_valid_o  <= 1'b0;
      resp_code_o   <= uhc_pkg::RESP_NONE;
      resp_toggle_o <= 1'b0;
      resp_len_o    <= 4'h0;
      dma_addr_o    <= 16'h0000;
      reg_rdata_o   <= 8'h00;
      suspend_o     <= 1'b0;
      resume_o      <= 1'b0;
      power_down_o  <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (tok_go)
      begin
        cur_ep  <= tok_idx;
        cur_pid <= tok_pid_i;
      end
      resp_valid_o <= (tok_in_go && in_resp != uhc_pkg::RESP_NONE)
                      || (rx_evt && rx_resp != uhc_pkg::RESP_NONE);
      resp_code_o  <= tok_in_go ? in_resp : (rx_evt ? rx_resp : uhc_pkg::RESP_NONE);
      if (tok_in_go)
      begin
        resp_toggle_o <= tok_tx[uhc_pkg::FLD_TOGGLE];
        resp_len_o    <= tok_tx[uhc_pkg::FLD_LOW_H:0];
      end
      // Base bits 15:6, endpoint slot of 16, transmit half at +8
      dma_addr_o   <= {dma_high, dma_low, cur_ep,
                       cur_pid == uhc_pkg::TOK_IN, dma_idx_i};
      reg_rdata_o  <= reg_re_i ? rd_mux : 8'h00;
      suspend_o    <= next_control[uhc_pkg::CT_SUSP];
      resume_o     <= next_control[uhc_pkg::CT_RESUME];
      power_down_o <= next_control[uhc_pkg::CT_PDWN];
    end
  end

  default clocking dcb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  a_tx_stall_resp: assert property (
    tok_in_go && tok_stat == uhc_pkg::STAT_STALL
    |=> resp_valid_o && resp_code_o == uhc_pkg::RESP_STALL)
    else $error("stalled IN not answered with STALL");

  a_in_done_nak: assert property (
    ev_in_ok && !tok_valid_i && !bus_rst
    |=> cur_tx[uhc_pkg::FLD_STAT_H:uhc_pkg::FLD_STAT_L] == uhc_pkg::STAT_NAK)
    else $error("transmit status not NAK after acknowledged IN");

  a_in_byte_count: assert property (
    tok_in_go && in_resp == uhc_pkg::RESP_DATA
    |=> resp_code_o == uhc_pkg::RESP_DATA && resp_len_o == $past(tok_tx[3:0]))
    else $error("sent length differs from byte count");

  a_rx_done_nak: assert property (
    ev_rx_ok && !tok_valid_i && !bus_rst
    |=> cur_rstat == uhc_pkg::STAT_NAK)
    else $error("receive status not NAK after correct OUT");

  a_setup_toggles: assert property (
    setup_tok && !bus_rst && !ev_in_ok && !ev_rx_ok
    |=> !cur_rx[uhc_pkg::FLD_TOGGLE] && cur_tx[uhc_pkg::FLD_TOGGLE])
    else $error("SETUP did not reset data toggles");

  a_rx_toggle_flip: assert property (
    ev_rx_ok && !tok_valid_i && !bus_rst
    |=> cur_rx[uhc_pkg::FLD_TOGGLE] != $past(cur_rx[uhc_pkg::FLD_TOGGLE]))
    else $error("receive toggle did not flip");

  a_ep0_fixed_bits: assert property (
    ep_rx[0][7] && ep_rx[0][3:0] == 4'h0)
    else $error("endpoint 0 receive fixed bits wrong");

  a_bus_reset_clear: assert property (
    bus_reset_i
    |=> dev_addr == 7'h00 && ep_tx[1][5:4] == uhc_pkg::STAT_DISABLED
        && ep_rx[0][5:4] == uhc_pkg::STAT_DISABLED && ep_rx[2][5:4] == uhc_pkg::STAT_DISABLED)
    else $error("USB reset left endpoint enabled");

  a_ctr_nak_all: assert property (
    tok_in_go && ctr && tok_stat == uhc_pkg::STAT_VALID
    |=> resp_valid_o && resp_code_o == uhc_pkg::RESP_NAK)
    else $error("valid endpoint not NAKed while flag set");

  a_token_frozen: assert property (
    ctr && $past(ctr) |-> $stable(tok_pid) && $stable(last_ep))
    else $error("token or endpoint changed while flag set");

  a_suspend_wake: assert property (
    control[uhc_pkg::CT_SUSP] && bus_activity_i
    |=> int_status[uhc_pkg::IS_SUSPEND_END_FLAG] && !control[uhc_pkg::CT_SUSP])
    else $error("activity in suspend not flagged");

  a_status_out_stall: assert property (
    rx_evt && rx_ok_i && stout_bad && !setup_bad && cur_rstat == uhc_pkg::STAT_VALID
    |=> resp_valid_o && resp_code_o == uhc_pkg::RESP_STALL)
    else $error("nonzero OUT not stalled under status-out");

endmodule // uhc_endpoint_ctrl

// File: testbench/uhc_host_model.sv
// Behavioural low-speed USB host: tokens, data packet ends and handshakes
`timescale 1ns/1ns
module uhc_host_model (
  input  wire logic       mclk_i,
  output logic            tok_valid_o,
  output logic      [1:0] tok_pid_o,
  output logic      [6:0] tok_addr_o,
  output logic      [3:0] tok_ep_o,
  output logic            rx_done_o,
  output logic            rx_ok_o,
  output logic            rx_pid_o,
  output logic      [3:0] rx_len_o,
  output logic            ack_o
);
  initial
  begin
    {tok_valid_o, tok_pid_o, tok_addr_o, tok_ep_o} = '0;
    {rx_done_o, rx_ok_o, rx_pid_o, rx_len_o, ack_o} = '0;
  end
  // Idle fields are inverted so a stale token never passes for a live one
  task automatic token(input logic [1:0] p, input logic [6:0] a, input logic [3:0] e);
    @(posedge mclk_i);
    tok_valid_o <= 1'b1;
    {tok_pid_o, tok_addr_o, tok_ep_o} <= {p, a, e};
    @(posedge mclk_i);
    tok_valid_o <= 1'b0;
    {tok_pid_o, tok_addr_o, tok_ep_o} <= ~{p, a, e};
  endtask
  // Packet end, possibly damaged on purpose by the bench
  task automatic data(input logic ok, input logic dp, input logic [3:0] n);
    @(posedge mclk_i);
    {rx_done_o, rx_ok_o, rx_pid_o, rx_len_o} <= {1'b1, ok, dp, n};
    @(posedge mclk_i);
    {rx_done_o, rx_ok_o, rx_pid_o, rx_len_o} <= {2'b00, ~dp, ~n};
  endtask
  task automatic ack();
    @(posedge mclk_i);
    ack_o <= 1'b1;
    @(posedge mclk_i);
    ack_o <= 1'b0;
  endtask
endmodule // uhc_host_model

// File: testbench/tb.sv
// Self-checking bench for the endpoint handshake controller
`timescale 1ns/1ns
module tb;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_we_i = 1'b0;
  logic        reg_re_i = 1'b0;
  logic        bus_reset_i = 1'b0;
  logic        bus_activity_i = 1'b0;
  logic [2:0]  dma_idx_i = 3'h0;
  logic        tok_valid_i, rx_done_i, rx_ok_i, rx_data_pid_i, hs_ack_i;
  logic [1:0]  tok_pid_i;
  logic [6:0]  tok_addr_i;
  logic [3:0]  tok_ep_i, rx_len_i, resp_len_o;
  logic [7:0]  reg_rdata_o;
  logic        resp_valid_o, resp_toggle_o, suspend_o, resume_o, power_down_o;
  logic [2:0]  resp_code_o;
  logic [15:0] dma_addr_o;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          seed;
  logic [6:0]  dev_addr;
  logic [9:0]  base;
  logic [3:0]  n, m, e, e2;

  uhc_endpoint_ctrl dut_u (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
    .reg_rdata_o, .tok_valid_i, .tok_pid_i, .tok_addr_i, .tok_ep_i, .rx_done_i, .rx_ok_i,
    .rx_data_pid_i, .rx_len_i, .hs_ack_i, .bus_reset_i, .bus_activity_i, .sof_i(1'b0),
    .dma_late_i(1'b0), .dma_idx_i, .resp_valid_o, .resp_code_o, .resp_toggle_o, .resp_len_o,
    .dma_addr_o, .suspend_o, .resume_o, .power_down_o);
  uhc_host_model host_u (.mclk_i, .tok_valid_o(tok_valid_i), .tok_pid_o(tok_pid_i),
    .tok_addr_o(tok_addr_i), .tok_ep_o(tok_ep_i), .rx_done_o(rx_done_i), .rx_ok_o(rx_ok_i),
    .rx_pid_o(rx_data_pid_i), .rx_len_o(rx_len_i), .ack_o(hs_ack_i));

  initial
  begin
    forever #4 mclk_i = ~mclk_i;
  end

  function automatic logic [7:0] epv(input logic [1:0] hi, input logic [1:0] s,
                                     input logic [3:0] l);
    return {hi, s, l};
  endfunction
  function automatic logic [2:0] expc(input logic [1:0] s);
    return (s == uhc_pkg::STAT_STALL) ? uhc_pkg::RESP_STALL : uhc_pkg::RESP_NAK;
  endfunction

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge mclk_i);
    reg_we_i <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] x);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge mclk_i);
    reg_re_i <= 1'b0;
    #1 check(nm, 16'(reg_rdata_o), 16'(x));
  endtask
  // One transaction; the answer is looked at in the single cycle it stands
  task automatic xfer(input logic [1:0] p, input logic [3:0] ep, input logic dp,
                      input logic ok, input logic ev, input logic [2:0] ec);
    host_u.token(p, dev_addr, ep);
    if (p != uhc_pkg::TOK_IN)
      host_u.data(ok, dp, 4'h3);
    #1;
    check("resp_valid", 16'(resp_valid_o), 16'(ev));
    if (ev)
      check("resp_code", 16'(resp_code_o), 16'(ec));
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #400000;
    error_cnt++;
    end_sim();
  end

  initial
  begin
    seed = 32'hDB686CA5;
    dev_addr = 7'($random(seed)) | 7'h01;
    base = 10'($random(seed));
    n = 4'($unsigned($random(seed)) % 9);
    m = 4'($unsigned($random(seed)) % 9);
    e = (4'($random(seed)) & 4'h7) | 4'h1;
    e2 = e | 4'h8;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    dma_idx_i <= 3'($random(seed));
    rchk("ep0_rx", uhc_pkg::OFF_EP0_RX, uhc_pkg::RST_EP0_RX);
    rchk("ep0_tx", uhc_pkg::OFF_EP0_TX, uhc_pkg::RST_EP_TX);
    rchk("control", uhc_pkg::OFF_CONTROL, uhc_pkg::RST_CONTROL);
    rchk("unmapped", 4'hF, 8'h00);
    @(posedge mclk_i);
    bus_activity_i <= 1'b1;
    @(posedge mclk_i);
    bus_activity_i <= 1'b0;
    rchk("int_status", uhc_pkg::OFF_INT_STATUS, 8'h04);
    check("suspend", 16'(suspend_o), 16'h0000);
    wr(uhc_pkg::OFF_INT_STATUS, 8'h00);
    wr(uhc_pkg::OFF_EP0_RX, 8'hFF);
    rchk("ep0_rx", uhc_pkg::OFF_EP0_RX, 8'hF0);
    wr(uhc_pkg::OFF_DEV_ADDR, {1'b0, dev_addr});
    wr(uhc_pkg::OFF_DMA_HIGH, base[9:2]);
    wr(uhc_pkg::OFF_DMA_LOW_ID, {base[1:0], 6'h00});
    // Control endpoint setup stage, receive toggle deliberately left at one
    wr(uhc_pkg::OFF_EP0_TX, epv(2'd0, uhc_pkg::STAT_NAK, n));
    wr(uhc_pkg::OFF_EP0_TX, epv(2'd0, uhc_pkg::STAT_VALID, n));
    xfer(uhc_pkg::TOK_SETUP, 4'h0, 1'b0, 1'b1, 1'b1, uhc_pkg::RESP_ACK);
    rchk("ep0_rx", uhc_pkg::OFF_EP0_RX, 8'hE0);
    rchk("ep0_tx", uhc_pkg::OFF_EP0_TX, epv(2'd1, uhc_pkg::STAT_NAK, n));
    rchk("int_status", uhc_pkg::OFF_INT_STATUS, 8'h20);
    wr(4'hA, epv(2'd0, uhc_pkg::STAT_DISABLED, e));
    wr(4'h9, epv(2'd0, uhc_pkg::STAT_VALID, m));
    xfer(uhc_pkg::TOK_IN, e, 1'b0, 1'b1, 1'b1, uhc_pkg::RESP_NAK);
    rchk("token_pid", uhc_pkg::OFF_TOKEN_PID, {uhc_pkg::TOK_SETUP, 6'h00});
    wr(uhc_pkg::OFF_INT_STATUS, 8'h00);
    xfer(uhc_pkg::TOK_IN, e, 1'b0, 1'b1, 1'b1, uhc_pkg::RESP_DATA);
    check("resp_len", 16'(resp_len_o), 16'(m));
    check("resp_toggle", 16'(resp_toggle_o), 16'h0000);
    host_u.ack();
    rchk("ep1_tx", 4'h9, epv(2'd1, uhc_pkg::STAT_NAK, m));
    rchk("token_pid", uhc_pkg::OFF_TOKEN_PID, {uhc_pkg::TOK_IN, 6'h00});
    check("dma_addr", dma_addr_o, {base, 2'd1, 1'b1, dma_idx_i});
    wr(uhc_pkg::OFF_INT_STATUS, 8'h00);
    wr(4'hA, epv(2'd0, uhc_pkg::STAT_VALID, e));
    xfer(uhc_pkg::TOK_OUT, e, 1'b1, 1'b1, 1'b1, uhc_pkg::RESP_ACK);
    rchk("ep1_rx", 4'hA, epv(2'd0, uhc_pkg::STAT_VALID, e));
    rchk("int_status", uhc_pkg::OFF_INT_STATUS, 8'h00);
    xfer(uhc_pkg::TOK_OUT, e, 1'b0, 1'b0, 1'b0, uhc_pkg::RESP_NONE);
    xfer(uhc_pkg::TOK_OUT, e, 1'b0, 1'b1, 1'b1, uhc_pkg::RESP_ACK);
    rchk("ep1_rx", 4'hA, epv(2'd1, uhc_pkg::STAT_NAK, e));
    wr(uhc_pkg::OFF_INT_STATUS, 8'h00);
    // Disabled, stall and NAK codes in both directions
    for (int i = 0; i < 3; i++)
    begin
      wr(4'hC, epv(2'd0, 2'(i), e2));
      wr(4'hB, epv(2'd0, 2'(i), 4'h0));
      xfer(uhc_pkg::TOK_IN, e2, 1'b0, 1'b1, i != 0, expc(2'(i)));
      xfer(uhc_pkg::TOK_OUT, e2, 1'b0, 1'b1, i != 0, expc(2'(i)));
    end
    wr(4'hC, epv(2'd0, uhc_pkg::STAT_VALID, e2));
    wr(4'hB, epv(2'd2, uhc_pkg::STAT_NAK, 4'h0));
    xfer(uhc_pkg::TOK_SETUP, e2, 1'b0, 1'b1, 1'b0, uhc_pkg::RESP_NONE);
    xfer(uhc_pkg::TOK_OUT, e2, 1'b0, 1'b1, 1'b1, uhc_pkg::RESP_STALL);
    @(posedge mclk_i);
    bus_reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    bus_reset_i <= 1'b0;
    dev_addr = 7'h00;
    rchk("dev_addr", uhc_pkg::OFF_DEV_ADDR, 8'h00);
    rchk("ep1_rx", 4'hA, uhc_pkg::RST_EP_RX);
    rchk("ep0_rx", uhc_pkg::OFF_EP0_RX, uhc_pkg::RST_EP0_RX);
    xfer(uhc_pkg::TOK_IN, 4'h0, 1'b0, 1'b1, 1'b0, uhc_pkg::RESP_NONE);
    wr(uhc_pkg::OFF_EP0_RX, 8'h30);
    xfer(uhc_pkg::TOK_OUT, 4'h0, 1'b0, 1'b1, 1'b1, uhc_pkg::RESP_ACK);
    // Software suspends after a silent bus, with resume forced and regulator on
    wr(uhc_pkg::OFF_CONTROL, 8'h0A);
    rchk("control", uhc_pkg::OFF_CONTROL, 8'h0A);
    check("suspend", 16'(suspend_o), 16'h0001);
    check("resume", 16'(resume_o), 16'h0001);
    check("power_down", 16'(power_down_o), 16'h0000);
    end_sim();
  end
endmodule // tb
